// file: rtl/tmev_defs.svh
`ifndef TMEV_DEFS_SVH
`define TMEV_DEFS_SVH

// register indices; byte address is four times the index
`define TMEV_PADDR_W        18
`define TMEV_IDX_W          16
`define TMEV_IDX_PRIO_LO    16'hFF10
`define TMEV_IDX_PRIO_HI    16'hFF11
`define TMEV_IDX_EN_LO      16'hFF15
`define TMEV_IDX_EN_HI      16'hFF18
`define TMEV_IDX_FLAG_LO    16'hFF1B
`define TMEV_IDX_FLAG_HI    16'hFF1E
`define TMEV_IDX_OUT_CTRL   16'hFF40
`define TMEV_IDX_PAIR_CTRL  16'hFF41

// implemented bits of each register
`define TMEV_PRIO_LO_MASK   8'h3C
`define TMEV_PRIO_HI_MASK   8'hF0
`define TMEV_OUT_CTRL_MASK  8'h3F
`define TMEV_PAIR_MASK      8'h0F
`define TMEV_REG_RESET      8'h00

// priority field positions per channel pair
`define TMEV_PRIO_LSB_CH01  2
`define TMEV_PRIO_LSB_CH23  4
`define TMEV_PRIO_LSB_CH45  4
`define TMEV_PRIO_LSB_CH67  6

// out control: wave enables in [3:0], inverted enables of ch2/ch3 at [5:4]
`define TMEV_OUT_INV_LSB    4

// exception vectors
`define TMEV_VEC_LO_BASE    24'h00_0024
`define TMEV_VEC_HI_BASE    24'h00_0048
`define TMEV_VEC_STEP       24'h00_0002
`define TMEV_VEC_LAST       24'h00_003A

// port pin slots
`define TMEV_PIN_A          0
`define TMEV_PIN_B          1
`define TMEV_PIN_C          2

`endif

// file: rtl/tmev_pkg.sv
package tmev_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
  } tmev_apb_req_t;

  typedef struct packed {
    logic [7:0]  prio_lo;
    logic [7:0]  prio_hi;
    logic [15:0] en;
    logic [15:0] flag;
    logic [3:0]  pair16;
    logic [3:0]  wave_oe;
    logic [1:0]  inv_oe;
    logic [7:0]  unf_d;
    logic [7:0]  cmp_d;
    logic [7:0]  wave;
    logic        disp_clk;
    logic [1:0]  sio_clk;
    logic [2:0]  pin_out;
    logic [2:0]  pin_oe;
    logic [31:0] prdata;
    logic        irq_any;
    logic [1:0]  irq_lvl;
    logic [23:0] irq_vec;
  } tmev_state_t;

endpackage

// file: rtl/tmev_top.sv
// Notes on behaviour
// - each compare-match or underflow strobe sets its own flag, raising a request.
// - a cleared enable bit suppresses the request of its flag.
// - each request is presented at a two-bit priority level 0 to 3.
// - pairs 0/1, 2/3 use low register fields; 4/5, 6/7 high register fields.
// - flag and enable bits share positions; ch0 compare first, others underflow first.
// - in eight-bit mode each channel sets its own flags independently.
// - in sixteen-bit pairing only the upper channel flags are set.
// - sixteen fixed vectors, descending by two within each group of four channels.
// - wave rises on underflow strobe fall, falls on compare strobe fall.
// - an inverted copy of the ch2/ch3 wave is also provided.
// - reload not above compare holds the wave high.
// - ch0/ch1 share one pin; ch2/ch3 share a true and an inverted pin.
// - an output enable overrides pin direction and data; otherwise static output.
// - with both enables set the higher channel drives the pin.
// - in pairing the wave comes from upper channel, gated only by its enable.
// - enable gating is unsynchronised; a glitch up to half a cycle is tolerated.
// - ch1 and ch7 underflow strobes clock serial channels 0 and 1.
// - ch5 underflow strobe clocks the display timing generator.
// - ch5 underflow is halved before reaching the display timing generator.
// - underflow events never stop the count; counting continues after reload.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "tmev_defs.svh"

module tmev_top #(
  parameter int NUM_CH = 8
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire tmev_pkg::tmev_apb_req_t apb_req,
  output      logic                   pready,
  output      logic [31:0]            prdata,
  output      logic                   pslverr,
  input  wire logic [NUM_CH-1:0]      cmp_match_stb,
  input  wire logic [NUM_CH-1:0]      underflow_stb,
  input  wire logic [NUM_CH-1:0]      reload_le_cmp,
  input  wire logic [2:0]             pin_direction_bit,
  input  wire logic [2:0]             pin_output_bit,
  output      logic [2:0]             pin_out,
  output      logic [2:0]             pin_oe,
  output      logic [2*NUM_CH-1:0]    irq_req,
  output      logic                   irq_any,
  output      logic [1:0]             irq_level,
  output      logic [23:0]            irq_vector,
  output      logic [1:0]             sio_clk,
  output      logic                   disp_clk
);

  if (NUM_CH != 8)
  begin : g_bad_num_ch
    $error("tmev_top serves exactly eight channels");
  end

  tmev_pkg::tmev_state_t st_r;
  tmev_pkg::tmev_state_t st_nxt;

  logic [`TMEV_IDX_W-1:0] idx;
  logic                   hit;
  logic [7:0]             rdat;
  logic                   wr_en;
  logic [15:0]            clr;
  logic [NUM_CH-1:0]      unf_rise;
  logic [NUM_CH-1:0]      cmp_rise;
  logic [NUM_CH-1:0]      unf_fall;
  logic [NUM_CH-1:0]      cmp_fall;
  logic [15:0]            ev_set;
  logic [1:0]             ev_lvl [16];
  logic [23:0]            ev_vec [16];
  logic [15:0]            req;
  logic                   found;
  logic [1:0]             best_lvl;
  logic [23:0]            best_vec;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data caught in the setup cycle

  assign idx     = apb_req.paddr[`TMEV_PADDR_W-1:2];
  assign pready  = 1'b1;
  assign pslverr = apb_req.psel & apb_req.penable & ~hit;
  assign prdata  = st_r.prdata;
  assign wr_en   = apb_req.psel & apb_req.penable & apb_req.pwrite & hit;

  always_comb
  begin
    hit  = (apb_req.paddr[1:0] == 2'b00);
    rdat = `TMEV_REG_RESET;
    case (idx)
      `TMEV_IDX_PRIO_LO:   rdat = st_r.prio_lo;
      `TMEV_IDX_PRIO_HI:   rdat = st_r.prio_hi;
      `TMEV_IDX_EN_LO:     rdat = st_r.en[7:0];
      `TMEV_IDX_EN_HI:     rdat = st_r.en[15:8];
      `TMEV_IDX_FLAG_LO:   rdat = st_r.flag[7:0];
      `TMEV_IDX_FLAG_HI:   rdat = st_r.flag[15:8];
      `TMEV_IDX_OUT_CTRL:  rdat = {2'b00, st_r.inv_oe, st_r.wave_oe};
      `TMEV_IDX_PAIR_CTRL: rdat = {4'h0, st_r.pair16};
      default:             hit  = 1'b0;
    endcase
  end

  // write one to clear a flag
  always_comb
  begin
    clr = 16'h0000;
    if (wr_en && idx == `TMEV_IDX_FLAG_LO)
    begin
      clr[7:0] = apb_req.pwdata[7:0];
    end
    if (wr_en && idx == `TMEV_IDX_FLAG_HI)
    begin
      clr[15:8] = apb_req.pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per channel event mapping

  assign unf_rise = underflow_stb & ~st_r.unf_d;
  assign cmp_rise = cmp_match_stb & ~st_r.cmp_d;
  assign unf_fall = ~underflow_stb & st_r.unf_d;
  assign cmp_fall = ~cmp_match_stb & st_r.cmp_d;

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    localparam int UB = (c == 0) ? 1 : 2 * c;
    localparam int CB = (c == 0) ? 0 : 2 * c + 1;
    localparam int PL = (c < 2) ? `TMEV_PRIO_LSB_CH01 :
                        (c < 4) ? `TMEV_PRIO_LSB_CH23 :
                        (c < 6) ? `TMEV_PRIO_LSB_CH45 : `TMEV_PRIO_LSB_CH67;
    logic masked;
    // lower half of a pair is silent; upper strobes carry the 16-bit events
    assign masked     = (c % 2 == 0) && st_r.pair16[c/2];
    assign ev_set[UB] = unf_rise[c] & ~masked;
    assign ev_set[CB] = cmp_rise[c] & ~masked;
    if (c < 4)
    begin : g_lo
      assign ev_lvl[UB] = st_r.prio_lo[PL+:2];
      assign ev_lvl[CB] = st_r.prio_lo[PL+:2];
      assign ev_vec[UB] = `TMEV_VEC_LO_BASE - 24'(`TMEV_VEC_STEP * UB);
      assign ev_vec[CB] = `TMEV_VEC_LO_BASE - 24'(`TMEV_VEC_STEP * CB);
    end
    else
    begin : g_hi
      assign ev_lvl[UB] = st_r.prio_hi[PL+:2];
      assign ev_lvl[CB] = st_r.prio_hi[PL+:2];
      assign ev_vec[UB] = `TMEV_VEC_HI_BASE - 24'(`TMEV_VEC_STEP * (UB - 8));
      assign ev_vec[CB] = `TMEV_VEC_HI_BASE - 24'(`TMEV_VEC_STEP * (CB - 8));
    end
  end

  assign req = st_r.flag & st_r.en;

  // highest level wins; on a tie the lower bit, i.e. the higher vector within its group of eight bits
  always_comb
  begin
    found    = 1'b0;
    best_lvl = 2'b00;
    best_vec = `TMEV_VEC_LO_BASE;
    for (int b = 15; b >= 0; b--)
    begin
      if (req[b] && (!found || ev_lvl[b] >= best_lvl))
      begin
        found    = 1'b1;
        best_lvl = ev_lvl[b];
        best_vec = ev_vec[b];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.unf_d = underflow_stb;
    st_nxt.cmp_d = cmp_match_stb;
    if (apb_req.psel && !apb_req.penable)
    begin
      st_nxt.prdata = {24'h00_0000, rdat};
    end
    if (wr_en)
    begin
      case (idx)
        `TMEV_IDX_PRIO_LO:   st_nxt.prio_lo = apb_req.pwdata[7:0] & `TMEV_PRIO_LO_MASK;
        `TMEV_IDX_PRIO_HI:   st_nxt.prio_hi = apb_req.pwdata[7:0] & `TMEV_PRIO_HI_MASK;
        `TMEV_IDX_EN_LO:     st_nxt.en[7:0] = apb_req.pwdata[7:0];
        `TMEV_IDX_EN_HI:     st_nxt.en[15:8] = apb_req.pwdata[7:0];
        `TMEV_IDX_OUT_CTRL:
        begin
          st_nxt.wave_oe = apb_req.pwdata[3:0];
          st_nxt.inv_oe  = apb_req.pwdata[`TMEV_OUT_INV_LSB+:2];
        end
        `TMEV_IDX_PAIR_CTRL: st_nxt.pair16 = apb_req.pwdata[3:0];
        default:             st_nxt.pair16 = st_r.pair16;
      endcase
    end
    // set beats clear; strobes only flag, never hold off the counter
    st_nxt.flag = (st_r.flag & ~clr) | ev_set;
    st_nxt.irq_any = found;
    st_nxt.irq_lvl = best_lvl;
    st_nxt.irq_vec = best_vec;
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (reload_le_cmp[c])
      begin
        st_nxt.wave[c] = 1'b1;
      end
      else if (unf_fall[c])
      begin
        st_nxt.wave[c] = 1'b1;
      end
      else if (cmp_fall[c])
      begin
        st_nxt.wave[c] = 1'b0;
      end
    end
    // enables gate the live wave; a toggle mid-period may clip a half cycle
    if (st_r.wave_oe[1])
    begin
      st_nxt.pin_out[`TMEV_PIN_A] = st_r.wave[1];
      st_nxt.pin_oe[`TMEV_PIN_A]  = 1'b1;
    end
    else if (st_r.wave_oe[0] && !st_r.pair16[0])
    begin
      st_nxt.pin_out[`TMEV_PIN_A] = st_r.wave[0];
      st_nxt.pin_oe[`TMEV_PIN_A]  = 1'b1;
    end
    else
    begin
      st_nxt.pin_out[`TMEV_PIN_A] = pin_output_bit[`TMEV_PIN_A];
      st_nxt.pin_oe[`TMEV_PIN_A]  = pin_direction_bit[`TMEV_PIN_A];
    end
    if (st_r.wave_oe[3])
    begin
      st_nxt.pin_out[`TMEV_PIN_B] = st_r.wave[3];
      st_nxt.pin_oe[`TMEV_PIN_B]  = 1'b1;
    end
    else if (st_r.wave_oe[2] && !st_r.pair16[1])
    begin
      st_nxt.pin_out[`TMEV_PIN_B] = st_r.wave[2];
      st_nxt.pin_oe[`TMEV_PIN_B]  = 1'b1;
    end
    else
    begin
      st_nxt.pin_out[`TMEV_PIN_B] = pin_output_bit[`TMEV_PIN_B];
      st_nxt.pin_oe[`TMEV_PIN_B]  = pin_direction_bit[`TMEV_PIN_B];
    end
    if (st_r.inv_oe[1])
    begin
      st_nxt.pin_out[`TMEV_PIN_C] = ~st_r.wave[3];
      st_nxt.pin_oe[`TMEV_PIN_C]  = 1'b1;
    end
    else if (st_r.inv_oe[0] && !st_r.pair16[1])
    begin
      st_nxt.pin_out[`TMEV_PIN_C] = ~st_r.wave[2];
      st_nxt.pin_oe[`TMEV_PIN_C]  = 1'b1;
    end
    else
    begin
      st_nxt.pin_out[`TMEV_PIN_C] = pin_output_bit[`TMEV_PIN_C];
      st_nxt.pin_oe[`TMEV_PIN_C]  = pin_direction_bit[`TMEV_PIN_C];
    end
    // compare value never reaches these clocks, only underflow strobes
    st_nxt.sio_clk = {underflow_stb[7], underflow_stb[1]};
    if (unf_rise[5])
    begin
      st_nxt.disp_clk = ~st_r.disp_clk;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pin_out    = st_r.pin_out;
  assign pin_oe     = st_r.pin_oe;
  assign irq_req    = req;
  assign irq_any    = st_r.irq_any;
  assign irq_level  = st_r.irq_lvl;
  assign irq_vector = st_r.irq_vec;
  assign sio_clk    = st_r.sio_clk;
  assign disp_clk   = st_r.disp_clk;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_flag_set;
    (underflow_stb[3] && !st_r.unf_d[3]) |=> st_r.flag[6];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("underflow did not set flag");
  property p_en_gate;
    (st_r.en == 16'h0000) |-> ##1 !st_r.irq_any;
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("request with all enables off");
  property p_level;
    (req == 16'h0001) |=> (irq_any && irq_level == $past(st_r.prio_lo[3:2]));
  endproperty
  a_level: assert property (p_level) else $error("wrong priority level");
  property p_prio_write;
    (wr_en && idx == `TMEV_IDX_PRIO_HI)
      |=> st_r.prio_hi[7:4] == $past(apb_req.pwdata[7:4]);
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority field lost");
  property p_vec_first;
    (req == 16'h0001) |=> irq_vector == `TMEV_VEC_LO_BASE;
  endproperty
  a_vec_first: assert property (p_vec_first) else $error("wrong first vector");
  property p_vec_last;
    (req == 16'h8000) |=> irq_vector == `TMEV_VEC_LAST;
  endproperty
  a_vec_last: assert property (p_vec_last) else $error("wrong last vector");
  property p_pair_mask;
    (st_r.pair16[0] && underflow_stb[0] && !st_r.unf_d[0] && !st_r.flag[1] && !clr[1])
      |=> !st_r.flag[1];
  endproperty
  a_pair_mask: assert property (p_pair_mask) else $error("lower channel flag set");
  property p_wave_fall;
    (cmp_fall[4] && !unf_fall[4] && !reload_le_cmp[4]) |=> !st_r.wave[4];
  endproperty
  a_wave_fall: assert property (p_wave_fall) else $error("wave did not fall");
  property p_wave_hold;
    reload_le_cmp[2] [*2] |-> st_r.wave[2];
  endproperty
  a_wave_hold: assert property (p_wave_hold) else $error("wave not held high");
  property p_pin_prio;
    (st_r.wave_oe[1:0] == 2'b11) |=> (pin_oe[0] && pin_out[0] == $past(st_r.wave[1]));
  endproperty
  a_pin_prio: assert property (p_pin_prio) else $error("lower channel drove pin");
  property p_static;
    (st_r.wave_oe[1:0] == 2'b00)
      |=> (pin_oe[0] == $past(pin_direction_bit[0]) && pin_out[0] == $past(pin_output_bit[0]));
  endproperty
  a_static: assert property (p_static) else $error("static output lost");
  property p_sticky;
    (st_r.flag[5] && !clr[5]) |=> st_r.flag[5];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_disp;
    unf_rise[5] |=> disp_clk != $past(disp_clk);
  endproperty
  a_disp: assert property (p_disp) else $error("display clock did not toggle");
  property p_sio;
    underflow_stb[7] |=> sio_clk[1];
  endproperty
  a_sio: assert property (p_sio) else $error("serial clock missing");
  c_irq:  cover property (irq_any ##1 clr != 16'h0000);
  c_pair: cover property (st_r.pair16[1] && st_r.wave_oe[3] && pin_oe[1]);
  c_set_clr: cover property (ev_set[3] && clr[3]);
  c_inv:  cover property (st_r.inv_oe[1] && pin_oe[2]);

endmodule // tmev_top

// file: tb/tmev_cnt_model.sv
`timescale 1ns/1ps

module tmev_cnt_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] fire_cmp,
  input  wire logic [7:0] fire_unf,
  input  wire logic       sio_clk0,
  output      logic [7:0] cmp_match_stb,
  output      logic [7:0] underflow_stb,
  output      logic [7:0] baud_cnt
);
  logic [7:0] cmp_d_r;
  logic [7:0] unf_d_r;
  logic       sio_d_r;
  logic [4:0] div_r;

  // a request becomes a two-cycle strobe, like one slow timer clock period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_d_r       <= 8'h00;
      unf_d_r       <= 8'h00;
      cmp_match_stb <= 8'h00;
      underflow_stb <= 8'h00;
      sio_d_r       <= 1'b0;
      div_r         <= 5'h00;
      baud_cnt      <= 8'h00;
    end
    else
    begin
      cmp_d_r       <= fire_cmp;
      unf_d_r       <= fire_unf;
      cmp_match_stb <= fire_cmp | cmp_d_r;
      underflow_stb <= fire_unf | unf_d_r;
      sio_d_r       <= sio_clk0;
      // serial side: one bit-rate tick per 32 routed underflows
      if (sio_clk0 && !sio_d_r)
      begin
        div_r <= div_r + 5'h01;
        if (div_r == 5'h1F)
        begin
          baud_cnt <= baud_cnt + 8'h01;
        end
      end
    end
  end
endmodule // tmev_cnt_model

// file: tb/tmev_top_tb.sv
`timescale 1ns/1ps
`include "tmev_defs.svh"

module tmev_top_tb;
  localparam logic [15:0] IX [9] = '{`TMEV_IDX_PRIO_LO, `TMEV_IDX_PRIO_HI,
    `TMEV_IDX_EN_LO, `TMEV_IDX_EN_HI, `TMEV_IDX_FLAG_LO, `TMEV_IDX_FLAG_HI,
    `TMEV_IDX_OUT_CTRL, `TMEV_IDX_PAIR_CTRL, 16'hFF12};
  localparam logic [7:0]  MK [9] = '{8'h3C, 8'hF0, 8'hFF, 8'hFF, 8'h00,
    8'h00, 8'h3F, 8'h0F, 8'h00};

  logic                    pclk;
  logic                    presetn;
  tmev_pkg::tmev_apb_req_t req;
  logic                    pready;
  logic [31:0]             prdata;
  logic                    pslverr;
  logic [7:0]              fc;
  logic [7:0]              fu;
  logic [7:0]              cms;
  logic [7:0]              ufs;
  logic [7:0]              rlc;
  logic [2:0]              dir;
  logic [2:0]              dat;
  logic [2:0]              pin_out;
  logic [2:0]              pin_oe;
  logic [15:0]             irq_req;
  logic                    irq_any;
  logic [1:0]              irq_level;
  logic [23:0]             irq_vector;
  logic [1:0]              sio_clk;
  logic                    disp_clk;
  logic [31:0]             rd;
  logic                    er;
  logic [15:0]             f;
  logic [7:0]              baud_cnt;
  int                      num_errors;
  int                      total_checks;

  tmev_top i_tmev_top (.pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cmp_match_stb(cms), .underflow_stb(ufs),
    .reload_le_cmp(rlc), .pin_direction_bit(dir), .pin_output_bit(dat),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq_req(irq_req), .irq_any(irq_any),
    .irq_level(irq_level), .irq_vector(irq_vector), .sio_clk(sio_clk),
    .disp_clk(disp_clk));

  tmev_cnt_model i_tmev_cnt_model (.pclk(pclk), .presetn(presetn), .fire_cmp(fc),
    .fire_unf(fu), .sio_clk0(sio_clk[0]), .cmp_match_stb(cms), .underflow_stb(ufs),
    .baud_cnt(baud_cnt));

  //////////////////////////////////////////////////////////////////////////////

  function automatic int ubit(int ch);
    return (ch == 0) ? 1 : 2 * ch;
  endfunction

  function automatic int cbit(int ch);
    return (ch == 0) ? 0 : 2 * ch + 1;
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] ix, input logic [7:0] d);
    @(posedge pclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= {ix, 2'b00};
    req.pwdata  <= 32'(d);
    @(posedge pclk);
    req.penable <= 1'b1;
    // only the watchdog ends a wait that never completes
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    chk(32'(pready), 32'h1);
  endtask

  task automatic fire(input logic [7:0] c, input logic [7:0] u);
    @(posedge pclk);
    fc <= c;
    fu <= u;
    @(posedge pclk);
    fc <= 8'h00;
    fu <= 8'h00;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic rf();
    apb(1'b0, `TMEV_IDX_FLAG_LO, 8'h00);
    f[7:0] = rd[7:0];
    apb(1'b0, `TMEV_IDX_FLAG_HI, 8'h00);
    f[15:8] = rd[7:0];
  endtask

  task automatic clr();
    apb(1'b1, `TMEV_IDX_FLAG_LO, 8'hFF);
    apb(1'b1, `TMEV_IDX_FLAG_HI, 8'hFF);
  endtask

  // pin outputs are registered once behind the wave, so let them land first
  task automatic pin(input int p, input logic o, input logic e);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(32'(pin_out[p]), 32'(o));
    chk(32'(pin_oe[p]), 32'(e));
  endtask

  //////////////////////////////////////////////////////////////////////////////

  task automatic t_regs();
    foreach (IX[i])
    begin
      apb(1'b0, IX[i], 8'h00);
      chk(rd, 32'h0);
      apb(1'b1, IX[i], 8'hFF);
      apb(1'b0, IX[i], 8'h00);
      chk(rd, 32'(MK[i]));
      chk(32'(er), (i == 8) ? 32'h1 : 32'h0);
      apb(1'b1, IX[i], 8'h00);
    end
  endtask

  task automatic t_clk();
    logic [1:0] seen;
    for (int k = 0; k < 2; k++)
    begin
      seen = 2'b00;
      @(posedge pclk);
      fu <= (k == 0) ? 8'h02 : 8'h80;
      @(posedge pclk);
      fu <= 8'h00;
      repeat (8)
      begin
        @(negedge pclk);
        seen |= sio_clk;
      end
      chk(32'(seen), 32'(k + 1));
    end
    // first channel 1 underflow above already counted once
    repeat (30) fire(8'h00, 8'h02);
    chk(32'(baud_cnt), 32'h0);
    fire(8'h00, 8'h02);
    chk(32'(baud_cnt), 32'h1);
    fire(8'h20, 8'h00);
    chk(32'(disp_clk), 32'h0);
    fire(8'h00, 8'h20);
    chk(32'(disp_clk), 32'h1);
    fire(8'h00, 8'h20);
    chk(32'(disp_clk), 32'h0);
  endtask

  task automatic t_flags();
    clr();
    for (int ch = 0; ch < 8; ch++)
    begin
      fire(8'h00, 8'(1 << ch));
      rf();
      chk(32'(f), 32'h1 << ubit(ch));
      fire(8'(1 << ch), 8'h00);
      fire(8'(1 << ch), 8'h00);
      rf();
      chk(32'(f), (32'h1 << ubit(ch)) | (32'h1 << cbit(ch)));
      clr();
      rf();
      chk(32'(f), 32'h0);
    end
  endtask

  task automatic t_irq();
    int l;
    fire(8'hFF, 8'hFF);
    for (int b = 0; b < 16; b++)
    begin
      l = b % 4;
      apb(1'b1, `TMEV_IDX_PRIO_LO, 8'(b < 4 ? l << 2 : (b < 8 ? l << 4 : 0)));
      apb(1'b1, `TMEV_IDX_PRIO_HI, 8'(b < 8 ? 0 : (b < 12 ? l << 4 : l << 6)));
      apb(1'b1, `TMEV_IDX_EN_LO, 8'(b < 8 ? 1 << b : 0));
      apb(1'b1, `TMEV_IDX_EN_HI, 8'(b < 8 ? 0 : 1 << (b - 8)));
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk(32'(irq_req), 32'h1 << b);
      chk(32'(irq_any), 32'h1);
      chk(32'(irq_level), 32'(l));
      chk(32'(irq_vector), b < 8 ? 32'h24 - 2 * b : 32'h48 - 2 * (b - 8));
    end
    apb(1'b1, `TMEV_IDX_EN_HI, 8'h00);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, irq_any}, 32'h0);
    clr();
  endtask

  task automatic t_pair();
    apb(1'b1, `TMEV_IDX_PAIR_CTRL, 8'h01);
    fire(8'h03, 8'h03);
    rf();
    chk(32'(f), 32'h0000_000C);
    apb(1'b1, `TMEV_IDX_PAIR_CTRL, 8'h00);
    clr();
  endtask

  task automatic t_wave();
    fire(8'h00, 8'hFF);
    fire(8'hFF, 8'h00);
    apb(1'b1, `TMEV_IDX_OUT_CTRL, 8'h01);
    fire(8'h00, 8'h01);
    pin(0, 1'b1, 1'b1);
    fire(8'h01, 8'h00);
    pin(0, 1'b0, 1'b1);
    fire(8'h00, 8'h01);
    apb(1'b1, `TMEV_IDX_OUT_CTRL, 8'h03);
    pin(0, 1'b0, 1'b1);
    apb(1'b1, `TMEV_IDX_PAIR_CTRL, 8'h01);
    apb(1'b1, `TMEV_IDX_OUT_CTRL, 8'h01);
    pin(0, dat[0], dir[0]);
    apb(1'b1, `TMEV_IDX_PAIR_CTRL, 8'h00);
    apb(1'b1, `TMEV_IDX_OUT_CTRL, 8'h14);
    fire(8'h00, 8'h04);
    pin(1, 1'b1, 1'b1);
    pin(2, 1'b0, 1'b1);
    apb(1'b1, `TMEV_IDX_OUT_CTRL, 8'h3C);
    pin(1, 1'b0, 1'b1);
    pin(2, 1'b1, 1'b1);
    apb(1'b1, `TMEV_IDX_OUT_CTRL, 8'h14);
    @(posedge pclk);
    rlc <= 8'h04;
    fire(8'h04, 8'h00);
    pin(1, 1'b1, 1'b1);
    @(posedge pclk);
    rlc <= 8'h00;
    fire(8'h04, 8'h00);
    pin(2, 1'b1, 1'b1);
    apb(1'b1, `TMEV_IDX_OUT_CTRL, 8'h00);
    pin(0, dat[0], dir[0]);
    chk({26'h0, pin_out, pin_oe}, {26'h0, dat, dir});
  endtask

  task automatic close_out();
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial
  begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    close_out();
  end

  initial
  begin
    presetn      = 1'b0;
    req          = '0;
    fc           = 8'h00;
    fu           = 8'h00;
    rlc          = 8'h00;
    dir          = 3'h5;
    dat          = 3'h2;
    num_errors   = 0;
    total_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clk();
    t_flags();
    t_irq();
    t_pair();
    t_wave();
    close_out();
  end
endmodule // tmev_top_tb
